// >>> rtl/rwc_top.sv
// Reset sequencing, reset pin control and supervisory watchdog
`default_nettype none
module rwc_top
  import rwc_pkg::*;
#(
  parameter bit POR_LONG = 1'b1,
  parameter bit WATCHDOG_ENABLE_BIT_AUTO_EN = 1'b0,
  parameter bit WAIT_WATCHDOG_ENABLE_BIT_RUN = 1'b1,
  parameter int POR_CYCLES = POR_LONG ? POR_LONG_CYCLES : POR_SHORT_CYCLES,
  parameter int WATCHDOG_ENABLE_BIT_PIN_HOLD_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic osc_active,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic timer_bit7_carry,
  input wire logic halt_exec,
  input wire logic wait_mode,
  output logic chip_reset,
  output logic irq_mask_set,
  output logic [15:0] start_vector,
  input wire rwc_apb_req_type apb_req,
  output var rwc_apb_rsp_type apb_rsp
);

  localparam logic [CNT_WIDTH-1:0] POR_LAST = CNT_WIDTH'(POR_CYCLES - 1);
  localparam logic [CNT_WIDTH-1:0] PIN_LOW_DONE = CNT_WIDTH'(PIN_MIN_LOW_CYCLES);
  localparam logic [CNT_WIDTH-1:0] HOLD_DONE = CNT_WIDTH'(WATCHDOG_ENABLE_BIT_PIN_HOLD_CYCLES);

  // Register decode, shared by write path and error answer
  function automatic logic is_misc(input logic [11:0] addr);
    is_misc = (addr == MISC_ADDR);
  endfunction

  rwc_state_type state;
  rwc_state_type next_state;
  logic osc_meta, osc_sync;
  logic pin_meta, pin_sync;
  logic [CNT_WIDTH-1:0] por_cnt;
  logic [CNT_WIDTH-1:0] pin_low_cnt;
  logic por_flag;
  logic watchdog_enable_bit_en;
  logic [DIV4_WIDTH-1:0] div4;
  logic [DIV256_WIDTH-1:0] div256;
  logic [WATCHDOG_ENABLE_BIT_CNT_WIDTH-1:0] watchdog_enable_bit_count;
  logic access;
  logic watchdog_enable_bit_write_one;
  logic por_write_zero;
  logic div4_carry, div256_carry;
  logic watchdog_enable_bit_hold;
  logic watchdog_enable_bit_timeout;
  logic halt_trap;
  logic drive_pin;

  // Two-stage synchronisers for the oscillator flag and the reset pin
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end else begin
      osc_meta <= osc_active;
      osc_sync <= osc_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= reset_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Consecutive low count of the synchronised pin, saturating
  always_ff @(posedge clk) begin
    if (reset || pin_sync) begin
      pin_low_cnt <= CNT_ZERO;
    end else if (pin_low_cnt != {CNT_WIDTH{1'b1}}) begin
      pin_low_cnt <= pin_low_cnt + CNT_ONE;
    end
  end

  // APB: one wait state, write lands on the edge where pready is seen
  assign access = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign watchdog_enable_bit_write_one = access && apb_req.pwrite && is_misc(apb_req.paddr)
    && apb_req.pwdata[WATCHDOG_ENABLE_BIT_BIT];
  assign por_write_zero = access && apb_req.pwrite && is_misc(apb_req.paddr)
    && !apb_req.pwdata[POR_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= apb_req.psel && apb_req.penable && !apb_rsp.pready;
      apb_rsp.pslverr <= apb_req.psel && apb_req.penable && !apb_rsp.pready
        && !is_misc(apb_req.paddr);
      if (apb_req.psel && apb_req.penable && !apb_rsp.pready
          && !apb_req.pwrite && is_misc(apb_req.paddr)) begin
        apb_rsp.prdata <= {READ_PAD[31:8], por_flag, MISC_RESERVED_READ[6:1], watchdog_enable_bit_en};
      end else begin
        apb_rsp.prdata <= READ_PAD;
      end
    end
  end

  // Power-on flag: only the power-on reset sets it
  always_ff @(posedge clk) begin
    if (reset) begin
      por_flag <= 1'b1;
    end else if (por_write_zero) begin
      por_flag <= 1'b0;
    end
  end

  // Watchdog enable: sticky once set, option value while out of run, zero while the reset input is high
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_enable_bit_en <= 1'b0;
    end else if (state != RWC_RUN) begin
      watchdog_enable_bit_en <= WATCHDOG_ENABLE_BIT_AUTO_EN;
    end else if (watchdog_enable_bit_write_one) begin
      watchdog_enable_bit_en <= 1'b1;
    end
  end

  // Idle mode with the stopped option holds the chain cleared
  assign watchdog_enable_bit_hold = wait_mode && !WAIT_WATCHDOG_ENABLE_BIT_RUN;
  assign div4_carry = timer_bit7_carry && (div4 == {DIV4_WIDTH{1'b1}});
  assign div256_carry = div4_carry && (div256 == {DIV256_WIDTH{1'b1}});

  // Fixed prescalers, cleared with the chip but not by a write of one, so a timeout after a kick can start mid-count
  always_ff @(posedge clk) begin
    if (reset || state != RWC_RUN || watchdog_enable_bit_hold) begin
      div4 <= '0;
      div256 <= '0;
    end else begin
      if (timer_bit7_carry) begin
        div4 <= div4 + DIV4_WIDTH'(1);
      end
      if (div4_carry) begin
        div256 <= div256 + DIV256_WIDTH'(1);
      end
    end
  end

  // Timeout counter, counts up to 7 and stops there; a write of one clears it
  always_ff @(posedge clk) begin
    if (reset || state != RWC_RUN || watchdog_enable_bit_hold || watchdog_enable_bit_write_one) begin
      watchdog_enable_bit_count <= WATCHDOG_ENABLE_BIT_CLEAR;
    end else if (watchdog_enable_bit_en && div256_carry && watchdog_enable_bit_count != WATCHDOG_ENABLE_BIT_FINAL) begin
      watchdog_enable_bit_count <= watchdog_enable_bit_count + WATCHDOG_ENABLE_BIT_CNT_WIDTH'(1);
    end
  end

  // A clearing write in the same cycle keeps the chip running
  assign watchdog_enable_bit_timeout = watchdog_enable_bit_en && (watchdog_enable_bit_count == WATCHDOG_ENABLE_BIT_FINAL) && !watchdog_enable_bit_write_one;
  assign halt_trap = watchdog_enable_bit_en && halt_exec;

  // Reset sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      RWC_OSC_WAIT: begin
        if (osc_sync) begin
          next_state = RWC_POR_DELAY;
        end
      end
      RWC_POR_DELAY: begin
        if (por_cnt == POR_LAST) begin
          next_state = RWC_PIN_HOLD;
        end
      end
      RWC_PIN_HOLD: begin
        if (pin_sync) begin
          next_state = RWC_RUN;
        end
      end
      RWC_WATCHDOG_ENABLE_BIT_PULL: begin
        if (pin_low_cnt >= HOLD_DONE) begin
          next_state = RWC_PIN_HOLD;
        end
      end
      RWC_RUN: begin
        if (watchdog_enable_bit_timeout || halt_trap) begin
          next_state = RWC_WATCHDOG_ENABLE_BIT_PULL;
        end else if (pin_low_cnt >= PIN_LOW_DONE) begin
          next_state = RWC_PIN_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= RWC_OSC_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Power-on delay counted from the synchronised oscillator flag
  always_ff @(posedge clk) begin
    if (reset || state != RWC_POR_DELAY) begin
      por_cnt <= CNT_ZERO;
    end else begin
      por_cnt <= por_cnt + CNT_ONE;
    end
  end

  // Pin pulled low for internal resets only; never driven high
  assign drive_pin = (next_state == RWC_OSC_WAIT) || (next_state == RWC_POR_DELAY)
    || (next_state == RWC_WATCHDOG_ENABLE_BIT_PULL);

  always_ff @(posedge clk) begin
    if (reset) begin
      reset_pin_oe <= 1'b1;
      reset_pin_out <= 1'b0;
    end else begin
      reset_pin_oe <= drive_pin;
      reset_pin_out <= 1'b0;
    end
  end

  // Core reset, vector and mask request
  always_ff @(posedge clk) begin
    if (reset) begin
      chip_reset <= 1'b1;
      irq_mask_set <= 1'b0;
      start_vector <= RESET_VECTOR;
    end else begin
      chip_reset <= (next_state != RWC_RUN);
      irq_mask_set <= (state != RWC_RUN) && (next_state == RWC_RUN);
      start_vector <= RESET_VECTOR;
    end
  end

  // Checks
  int unsigned por_len;
  always_ff @(posedge clk) begin
    if (reset || state != RWC_POR_DELAY) begin
      por_len <= 0;
    end else begin
      por_len <= por_len + 1;
    end
  end

  sequence s_halt_enabled;
    state == RWC_RUN && watchdog_enable_bit_en && halt_exec;
  endsequence
  sequence s_pull_pin;
    state == RWC_WATCHDOG_ENABLE_BIT_PULL ##1 reset_pin_oe;
  endsequence

  property p_por_pin_driven;
    @(posedge clk) disable iff (reset) state == RWC_POR_DELAY |-> reset_pin_oe && !reset_pin_out;
  endproperty
  a_por_pin_driven: assert property (p_por_pin_driven) else $error("pin idle in delay");

  property p_por_length;
    @(posedge clk) disable iff (reset) state == RWC_POR_DELAY |-> por_len < POR_CYCLES;
  endproperty
  a_por_length: assert property (p_por_length) else $error("power-on delay too long");

  property p_delay_to_hold;
    @(posedge clk) disable iff (reset)
      state == RWC_POR_DELAY && por_len == POR_CYCLES - 1 |=> state == RWC_PIN_HOLD;
  endproperty
  a_delay_to_hold: assert property (p_delay_to_hold) else $error("delay did not end");

  property p_resume;
    @(posedge clk) disable iff (reset)
      state == RWC_PIN_HOLD && pin_sync |=> !chip_reset && irq_mask_set ##1 !irq_mask_set;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after pin high");

  property p_por_flag;
    @(posedge clk) $fell(reset) |-> por_flag;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");

  property p_por_clear;
    @(posedge clk) disable iff (reset) por_write_zero |=> !por_flag;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on flag not cleared");

  property p_no_disable;
    @(posedge clk) disable iff (reset)
      state == RWC_RUN && next_state == RWC_RUN && watchdog_enable_bit_en |=> watchdog_enable_bit_en;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("watchdog disabled");

  property p_kick_clears;
    @(posedge clk) disable iff (reset) watchdog_enable_bit_write_one |=> watchdog_enable_bit_count == WATCHDOG_ENABLE_BIT_CLEAR;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("counter not cleared");

  property p_timeout;
    @(posedge clk) disable iff (reset)
      state == RWC_RUN && watchdog_enable_bit_timeout |=> chip_reset ##0 reset_pin_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout missed");

  property p_halt;
    @(posedge clk) disable iff (reset) s_halt_enabled |=> s_pull_pin;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not trapped");

  property p_halt_no_delay;
    @(posedge clk) disable iff (reset)
      state == RWC_WATCHDOG_ENABLE_BIT_PULL |=> state inside {RWC_WATCHDOG_ENABLE_BIT_PULL, RWC_PIN_HOLD};
  endproperty
  a_halt_no_delay: assert property (p_halt_no_delay) else $error("delay re-entered");

  property p_option_after;
    @(posedge clk) disable iff (reset)
      state == RWC_PIN_HOLD && pin_sync |=> watchdog_enable_bit_en == WATCHDOG_ENABLE_BIT_AUTO_EN;
  endproperty
  a_option_after: assert property (p_option_after) else $error("enable not option");

  property p_idle_stop;
    @(posedge clk) disable iff (reset) watchdog_enable_bit_hold |=> watchdog_enable_bit_count == WATCHDOG_ENABLE_BIT_CLEAR;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle did not stop");

endmodule
`default_nettype wire

// >>> include/rwc_pkg.sv
// Constants, types and register layout for reset and watchdog control
`default_nettype none
package rwc_pkg;
  // Register map: one byte-wide register in the low bits of an aligned word
  localparam logic [11:0] MISC_ADDR = 12'h00C;
  localparam int POR_BIT = 7;
  localparam int WATCHDOG_ENABLE_BIT_BIT = 0;
  localparam logic [7:0] MISC_RESERVED_READ = 8'h00;
  localparam logic [31:0] READ_PAD = 32'h0000_0000;
  // Start vector fetched after any reset
  localparam logic [15:0] RESET_VECTOR = 16'h1FFE;
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MACHINE_CYCLE_NS = 100;
  localparam int PIN_MIN_LOW_NS = 150;  // 1.5 machine cycles
  localparam int PIN_MIN_LOW_CYCLES = (PIN_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Power-on delay choices
  localparam int POR_SHORT_CYCLES = 16;
  localparam int POR_LONG_CYCLES = 4064;
  // Watchdog chain
  localparam int DIV4_WIDTH = 2;
  localparam int DIV256_WIDTH = 8;
  localparam int WATCHDOG_ENABLE_BIT_CNT_WIDTH = 3;
  localparam logic [WATCHDOG_ENABLE_BIT_CNT_WIDTH-1:0] WATCHDOG_ENABLE_BIT_FINAL = 3'h7;
  localparam logic [WATCHDOG_ENABLE_BIT_CNT_WIDTH-1:0] WATCHDOG_ENABLE_BIT_CLEAR = 3'h0;
  localparam int CNT_WIDTH = 12;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = 12'h001;

  typedef enum logic [2:0] {
    RWC_OSC_WAIT,
    RWC_POR_DELAY,
    RWC_PIN_HOLD,
    RWC_WATCHDOG_ENABLE_BIT_PULL,
    RWC_RUN
  } rwc_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rwc_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rwc_apb_rsp_type;
endpackage
`default_nettype wire

// >>> testbench/rwc_pin_board.sv
// Board model of the reset pin: pull-up, open-drain device, external switch
`default_nettype none
module rwc_pin_board (
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic ext_pull_low,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired level: either pull-down wins, else the pull-up gives a clean high
  assign pin_level = (reset_pin_oe ? reset_pin_out : 1'b1) & ~ext_pull_low;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for reset sequencing, reset pin and watchdog
`default_nettype none
module tb;
  import rwc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_N = 40;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic osc_active = 1'b0;
  logic ext_pull_low = 1'b0;
  logic pin_level;
  logic reset_pin_out;
  logic reset_pin_oe;
  logic carry = 1'b0;
  logic halt_exec = 1'b0;
  logic wait_mode = 1'b0;
  logic chip_reset;
  logic irq_mask_set;
  logic [15:0] start_vector;
  rwc_apb_req_type req = '0;
  rwc_apb_rsp_type rsp;
  logic [31:0] rd;
  logic [31:0] rd_b;
  logic err;
  logic pin_level_b;
  logic reset_pin_out_b;
  logic reset_pin_oe_b;
  logic chip_reset_b;
  rwc_apb_rsp_type rsp_b;
  int bad_count = 0;
  int n_compared = 0;
  int n;

  // Bus clock, 100 ns period
  always #50 clk = ~clk;

  rwc_pin_board board (.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .ext_pull_low(ext_pull_low), .pin_level(pin_level));

  // Short delay option keeps the run brief
  rwc_top #(.POR_LONG(1'b0), .POR_CYCLES(POR_N)) dut (.clk(clk), .reset(reset),
    .osc_active(osc_active), .reset_pin_in(pin_level), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .timer_bit7_carry(carry), .halt_exec(halt_exec),
    .wait_mode(wait_mode), .chip_reset(chip_reset), .irq_mask_set(irq_mask_set),
    .start_vector(start_vector), .apb_req(req), .apb_rsp(rsp));

  // Second unit with the other options: auto enable, watchdog stopped in idle
  rwc_pin_board board_b (.reset_pin_out(reset_pin_out_b), .reset_pin_oe(reset_pin_oe_b),
    .ext_pull_low(ext_pull_low), .pin_level(pin_level_b));

  rwc_top #(.POR_LONG(1'b0), .POR_CYCLES(POR_N), .WATCHDOG_ENABLE_BIT_AUTO_EN(1'b1), .WAIT_WATCHDOG_ENABLE_BIT_RUN(1'b0))
    dut_b (.clk(clk), .reset(reset), .osc_active(osc_active), .reset_pin_in(pin_level_b),
    .reset_pin_out(reset_pin_out_b), .reset_pin_oe(reset_pin_oe_b), .timer_bit7_carry(carry),
    .halt_exec(halt_exec), .wait_mode(wait_mode), .chip_reset(chip_reset_b),
    .irq_mask_set(), .start_vector(), .apb_req(req), .apb_rsp(rsp_b));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends a missing answer
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    rd_b = rsp_b.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // Timer carries every other cycle; stops early once the chip is in reset
  task automatic carries(input int k);
    n = 0;
    while (n < k && chip_reset !== 1'b1) begin
      carry <= 1'b1;
      @(posedge clk);
      carry <= 1'b0;
      @(posedge clk);
      n++;
    end
  endtask

  // Bounded wait for the core to leave reset
  task automatic wait_run(input int lim);
    n = 0;
    while (chip_reset !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    // A wait that runs out is a mismatch in its own right
    if (chip_reset !== 1'b0) begin
      bad_count++;
      $display("FAIL wait_run expected 0 seen %b", chip_reset);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well beyond the expected 37k cycles
  initial begin
    #8000000;
    bad_count++;
    print_verdict;
  end

  // Main sequence
  initial begin
    cyc(2);
    reset <= 1'b0;
    cyc(3);
    check("oe before osc", reset_pin_oe, 32'h1);
    osc_active <= 1'b1;
    ext_pull_low <= 1'b1;
    cyc(POR_N);
    check("pin driven in delay", reset_pin_oe, 32'h1);
    check("pin driven to zero", reset_pin_out, 32'h0);
    check("chip held", chip_reset, 32'h1);
    cyc(30);
    check("oe released after delay", reset_pin_oe, 32'h0);
    check("held while pin low", chip_reset, 32'h1);
    ext_pull_low <= 1'b0;
    wait_run(6);
    check("resume after pin high", n < 6, 32'h1);
    check("mask pulse", irq_mask_set, 32'h1);
    check("vector", start_vector, 32'h1FFE);
    // Flag set by power-on, cleared by zero, never set by software
    apb(1'b0, MISC_ADDR, 32'h0);
    check("misc after power-on", rd, 32'h80);
    check("auto-enabled after power-on", rd_b, 32'h81);
    apb(1'b1, MISC_ADDR, 32'h0);
    apb(1'b1, MISC_ADDR, 32'h80);
    apb(1'b0, MISC_ADDR, 32'h0);
    check("flag cleared not set", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", err, 32'h1);
    // Glitch on the pin is ignored, a long pull resets
    ext_pull_low <= 1'b1;
    @(posedge clk);
    ext_pull_low <= 1'b0;
    cyc(6);
    check("short pulse ignored", chip_reset, 32'h0);
    ext_pull_low <= 1'b1;
    cyc(6);
    check("pin reset", chip_reset, 32'h1);
    ext_pull_low <= 1'b0;
    wait_run(8);
    apb(1'b0, MISC_ADDR, 32'h0);
    check("pin reset keeps flag clear", rd, 32'h0);
    // Watchdog in idle mode: kick, then let it expire
    wait_mode <= 1'b1;
    apb(1'b1, MISC_ADDR, 32'h1);
    apb(1'b0, MISC_ADDR, 32'h0);
    check("enable set", rd, 32'h1);
    apb(1'b1, MISC_ADDR, 32'h0);
    carries(6000);
    apb(1'b1, MISC_ADDR, 32'h1);
    carries(6000);
    check("kick avoids timeout", chip_reset, 32'h0);
    apb(1'b0, MISC_ADDR, 32'h0);
    check("zero write kept enable", rd, 32'h1);
    apb(1'b1, MISC_ADDR, 32'h1);
    carries(8000);
    check("timeout window", n > 6144 && n <= 7170, 32'h1);
    check("idle stop holds off timeout", chip_reset_b, 32'h0);
    check("pin pulled by watchdog", reset_pin_oe, 32'h1);
    check("pin level low by watchdog", pin_level, 32'h0);
    wait_run(40);
    check("resumed", chip_reset, 32'h0);
    apb(1'b0, MISC_ADDR, 32'h0);
    check("enable back to option", rd, 32'h0);
    // Halt while enabled acts as a fast watchdog reset
    wait_mode <= 1'b0;
    apb(1'b1, MISC_ADDR, 32'h1);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    cyc(2);
    check("halt gives reset", chip_reset, 32'h1);
    check("halt traps auto-enabled", chip_reset_b, 32'h1);
    wait_run(POR_N);
    check("no start-up delay", n < POR_N, 32'h1);
    print_verdict;
  end
endmodule
`default_nettype wire
